// ===== hw/oetc_pkg.sv
package oetc_pkg;
   // ==========================================================
   // register map (word offsets chosen locally)
   localparam logic [3:0] OETC_ADDR_MANUAL = 4'h0;
   localparam logic [3:0] OETC_ADDR_FREQ = 4'h1;
   localparam logic [3:0] OETC_ADDR_TRIM = 4'h2;
   localparam logic [3:0] OETC_ADDR_ACT = 4'h3;
   localparam logic [3:0] OETC_ADDR_PWR = 4'h4;
   localparam logic [3:0] OETC_ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] OETC_ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] OETC_ADDR_TRIM_OUT = 4'h7;

   // ==========================================================
   // field positions
   localparam int OETC_BIT_EXT = 7;
   localparam int OETC_BIT_FAST = 6;
   localparam int OETC_BIT_MID = 5;
   localparam int OETC_BIT_SLOW = 4;
   localparam int OETC_BIT_SEC = 3;
   localparam int OETC_BIT_RC = 2;
   localparam int OETC_BIT_AUTO_EN = 7;
   localparam int OETC_BIT_PAUSE = 6;
   localparam int OETC_BIT_LOCK = 3;
   localparam int OETC_BIT_ORS = 1;
   localparam int OETC_BIT_SEC_PWR = 0;

   // ==========================================================
   // masks and reset values
   localparam logic [7:0] OETC_MANUAL_MASK = 8'hfc;
   localparam logic [7:0] OETC_MANUAL_RST = 8'h00;
   localparam logic [7:0] OETC_ACT_RST = 8'h00;
   localparam logic [5:0] OETC_TRIM_RST = 6'h00;
   localparam logic [5:0] OETC_TRIM_MAX = 6'h1f;
   localparam logic [5:0] OETC_TRIM_MIN = 6'h20;
   localparam logic [5:0] OETC_TRIM_ONE = 6'h01;
   localparam logic [2:0] OETC_IRQ_NONE = 3'h0;

   // ==========================================================
   // frequency select codes
   localparam logic [2:0] OETC_FRQ_4MHZ = 3'h2;
   localparam logic [2:0] OETC_FRQ_32MHZ = 3'h6;
   localparam logic [2:0] OETC_FRQ_RSVD = 3'h7;
   localparam logic [2:0] OETC_RESET_CLOCK_SOURCE_CONFIG_FAST4 = 3'h6;
   localparam logic [2:0] OETC_RESET_CLOCK_SOURCE_CONFIG_FAST32 = 3'h0;

   // interrupt status bits
   localparam int OETC_IRQ_LOCK = 0;
   localparam int OETC_IRQ_UNLOCK = 1;
   localparam int OETC_IRQ_ORS = 2;

   // trim comparator verdict from the reference
   typedef enum logic [1:0] {
      OETC_CMP_OK,
      OETC_CMP_SLOW,
      OETC_CMP_FAST
   } oetc_cmp_t;
endpackage : oetc_pkg

// ===== hw/oetc_freq_decode.sv
`timescale 1ns/10ps
// decodes the select code into a nominal frequency in MHz
module oetc_freq_decode (
   // select code
   input wire logic [2:0] sel,
   // decoded frequency, zero for the reserved code
   output logic [5:0] mhz,
   output logic reserved
);
   import oetc_pkg::*;

   // fixed frequency table
   always_comb begin
      reserved = 1'b0;
      case (sel)
         3'h0: mhz = 6'h01;
         3'h1: mhz = 6'h02;
         3'h2: mhz = 6'h04;
         3'h3: mhz = 6'h08;
         3'h4: mhz = 6'h0c;
         3'h5: mhz = 6'h10;
         3'h6: mhz = 6'h20;
         default: begin
            mhz = 6'h00;
            reserved = 1'b1;
         end
      endcase
   end
endmodule : oetc_freq_decode

// ===== hw/oetc_trim_step.sv
`timescale 1ns/10ps
// one saturating step of the signed trim toward nominal
module oetc_trim_step (
   // current trim and comparator verdict
   input wire logic [5:0] trim_in,
   input wire oetc_pkg::oetc_cmp_t verdict,
   // next trim and saturation flag
   output logic [5:0] trim_out,
   output logic at_limit
);
   import oetc_pkg::*;

   // slow oscillator needs a higher code, fast one lower
   always_comb begin
      trim_out = trim_in;
      at_limit = 1'b0;
      case (verdict)
         OETC_CMP_SLOW: begin
            if (trim_in == OETC_TRIM_MAX) at_limit = 1'b1;
            else trim_out = trim_in + OETC_TRIM_ONE;
         end
         OETC_CMP_FAST: begin
            if (trim_in == OETC_TRIM_MIN) at_limit = 1'b1;
            else trim_out = trim_in - OETC_TRIM_ONE;
         end
         default: trim_out = trim_in;
      endcase
   end
endmodule : oetc_trim_step

// ===== hw/oetc_osc_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// - manual bits keep mid, slow, rc running
// - external manual bit enables external in mode
// - fast manual bit runs fast oscillator selected
// - secondary manual bit runs it at power
// - select code sets nominal frequency; 111 reserved
// - reset select follows reset clock config
// - trim is signed, monotonic max to min
// - zero trim is centre, default
// - auto trim on makes trim read-only
// - auto trim on: hardware drives oscillator trim
// - pause blocks hardware and software trim writes
// - auto trim on, unpaused: trim updates every tuning event
// - lock bit set within one percent
// - out-of-range bit follows needed trim range
// - unimplemented bits read as zero
// - secondary power bit: one high, zero low
module oetc_osc_control (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // configuration word straps
   input wire logic [2:0] reset_clock_source_config,
   input wire logic [2:0] external_clock_mode_config,
   // requests from other modules
   input wire logic ext_osc_module_req,
   input wire logic fast_osc_module_req,
   input wire logic mid_osc_module_req,
   input wire logic slow_osc_module_req,
   input wire logic secondary_osc_module_req,
   input wire logic rc_osc_module_req,
   // tuning reference
   input wire logic tune_event,
   input wire oetc_pkg::oetc_cmp_t tune_verdict,
   input wire logic tune_in_band,
   // oscillator controls
   output logic external_oscillator_en,
   output logic [2:0] external_oscillator_mode,
   output logic fast_internal_oscillator_en,
   output logic [2:0] fast_osc_freq_select,
   output logic [5:0] fast_osc_freq_mhz,
   output logic [5:0] fast_osc_trim,
   output logic mid_internal_oscillator_en,
   output logic slow_internal_oscillator_en,
   output logic secondary_osc_en,
   output logic secondary_osc_high_power,
   output logic fast_rc_oscillator_en,
   // interrupt
   output logic irq
);
   import oetc_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] manual;
      logic [2:0] freq;
      logic [5:0] trim;
      logic auto_en;
      logic pause;
      logic locked;
      logic ors;
      logic sec_pwr;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic strap_done;
      logic [7:0] rdata;
   } oetc_state_t;

   oetc_state_t s_q;
   oetc_state_t s_d;
   logic [5:0] step_trim;
   logic step_limit;
   logic [5:0] dec_mhz;
   logic dec_rsvd;
   logic [7:0] rd_mux;
   logic [2:0] irq_set;
   logic hw_update;

   // ==========================================================
   // helpers
   oetc_trim_step u_step (
      .trim_in(s_q.trim),
      .verdict(tune_verdict),
      .trim_out(step_trim),
      .at_limit(step_limit)
   );

   oetc_freq_decode u_dec (
      .sel(s_q.freq),
      .mhz(dec_mhz),
      .reserved(dec_rsvd)
   );

   // hardware trim update only when enabled, unpaused, and event seen
   assign hw_update = s_q.auto_en & ~s_q.pause & tune_event;

   // ==========================================================
   // read mux, unused bits are zero
   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         OETC_ADDR_MANUAL: rd_mux = s_q.manual & OETC_MANUAL_MASK;
         OETC_ADDR_FREQ: rd_mux[2:0] = s_q.freq;
         OETC_ADDR_TRIM: rd_mux[5:0] = s_q.trim;
         OETC_ADDR_ACT: begin
            rd_mux[OETC_BIT_AUTO_EN] = s_q.auto_en;
            rd_mux[OETC_BIT_PAUSE] = s_q.pause;
            rd_mux[OETC_BIT_LOCK] = s_q.locked;
            rd_mux[OETC_BIT_ORS] = s_q.ors;
         end
         OETC_ADDR_PWR: rd_mux[OETC_BIT_SEC_PWR] = s_q.sec_pwr;
         OETC_ADDR_IRQ_STAT: rd_mux[2:0] = s_q.irq_stat;
         OETC_ADDR_IRQ_MASK: rd_mux[2:0] = s_q.irq_mask;
         OETC_ADDR_TRIM_OUT: rd_mux[5:0] = fast_osc_trim;
         default: rd_mux = 8'h00;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      irq_set = OETC_IRQ_NONE;
      // read data stands only in the cycle after the strobe
      s_d.rdata = reg_rd ? rd_mux : 8'h00;

      // straps sampled once after reset release, not in the reset branch
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         if (reset_clock_source_config == OETC_RESET_CLOCK_SOURCE_CONFIG_FAST32) begin
            s_d.freq = OETC_FRQ_32MHZ;
         end else begin
            s_d.freq = OETC_FRQ_4MHZ;
         end
      end

      // software writes
      if (reg_wr) begin
         case (reg_addr)
            OETC_ADDR_MANUAL: s_d.manual = reg_wdata & OETC_MANUAL_MASK;
            OETC_ADDR_FREQ: s_d.freq = reg_wdata[2:0];
            OETC_ADDR_TRIM: begin
               // locked out while hardware owns it or while paused
               if (!s_q.auto_en && !s_q.pause) s_d.trim = reg_wdata[5:0];
            end
            OETC_ADDR_ACT: begin
               s_d.auto_en = reg_wdata[OETC_BIT_AUTO_EN];
               s_d.pause = reg_wdata[OETC_BIT_PAUSE];
            end
            OETC_ADDR_PWR: s_d.sec_pwr = reg_wdata[OETC_BIT_SEC_PWR];
            OETC_ADDR_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[2:0];
            OETC_ADDR_IRQ_MASK: s_d.irq_mask = reg_wdata[2:0];
            default: s_d.manual = s_q.manual;
         endcase
      end

      // hardware tuning
      if (hw_update) begin
         s_d.trim = step_trim;
         s_d.ors = step_limit;
         s_d.locked = tune_in_band & ~step_limit;
      end
      if (!s_q.auto_en) begin
         // status meaningless without the tuner
         s_d.locked = 1'b0;
         s_d.ors = 1'b0;
      end

      // events: set wins over the write-one clear
      irq_set[OETC_IRQ_LOCK] = s_d.locked & ~s_q.locked;
      irq_set[OETC_IRQ_UNLOCK] = s_q.locked & ~s_d.locked;
      irq_set[OETC_IRQ_ORS] = s_d.ors & ~s_q.ors;
      s_d.irq_stat = s_d.irq_stat | irq_set;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q.manual <= OETC_MANUAL_RST;
         s_q.freq <= OETC_FRQ_4MHZ;
         s_q.trim <= OETC_TRIM_RST;
         s_q.auto_en <= OETC_ACT_RST[OETC_BIT_AUTO_EN];
         s_q.pause <= OETC_ACT_RST[OETC_BIT_PAUSE];
         s_q.locked <= 1'b0;
         s_q.ors <= 1'b0;
         s_q.sec_pwr <= 1'b0;
         s_q.irq_stat <= OETC_IRQ_NONE;
         s_q.irq_mask <= OETC_IRQ_NONE;
         s_q.strap_done <= 1'b0;
         s_q.rdata <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata = s_q.rdata;
   assign irq = |(s_q.irq_stat & s_q.irq_mask);
   // manual request or module request keeps each source on
   assign external_oscillator_en = s_q.manual[OETC_BIT_EXT] | ext_osc_module_req;
   assign external_oscillator_mode = external_clock_mode_config;
   assign fast_internal_oscillator_en = s_q.manual[OETC_BIT_FAST] | fast_osc_module_req;
   assign fast_osc_freq_select = s_q.freq;
   // reserved code yields zero; the analog side must treat it as unsupported
   assign fast_osc_freq_mhz = dec_rsvd ? 6'h00 : dec_mhz;
   // trim word is the register in both modes; the tuner writes it
   assign fast_osc_trim = s_q.trim;
   assign mid_internal_oscillator_en = s_q.manual[OETC_BIT_MID] | mid_osc_module_req;
   assign slow_internal_oscillator_en = s_q.manual[OETC_BIT_SLOW] | slow_osc_module_req;
   assign secondary_osc_en = s_q.manual[OETC_BIT_SEC] | secondary_osc_module_req;
   assign secondary_osc_high_power = s_q.sec_pwr;
   assign fast_rc_oscillator_en = s_q.manual[OETC_BIT_RC] | rc_osc_module_req;
endmodule : oetc_osc_control

// ===== tb/oetc_osc_control_assertions.sv
`timescale 1ns/10ps
// ==========================================================
// port-level checks, single clock domain
module oetc_chk import oetc_pkg::*; (
   // clock, reset, register port
   input wire logic clk, nrst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr, reg_rd,
   input wire logic [7:0] reg_rdata,
   // straps, requests, tuning
   input wire logic [2:0] reset_clock_source_config, external_clock_mode_config,
   input wire logic ext_osc_module_req, fast_osc_module_req, mid_osc_module_req,
   input wire logic slow_osc_module_req, secondary_osc_module_req, rc_osc_module_req,
   input wire logic tune_event,
   // oscillator controls
   input wire logic external_oscillator_en, fast_internal_oscillator_en,
   input wire logic mid_internal_oscillator_en, slow_internal_oscillator_en,
   input wire logic secondary_osc_en, fast_rc_oscillator_en,
   input wire logic [2:0] external_oscillator_mode, fast_osc_freq_select,
   input wire logic [5:0] fast_osc_freq_mhz, fast_osc_trim
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // reference decode, kept apart from the design's own decoder
   function automatic logic [5:0] mhz_of(input logic [2:0] s);
      case (s)
         3'h0: mhz_of = 6'd1;
         3'h1: mhz_of = 6'd2;
         3'h2: mhz_of = 6'd4;
         3'h3: mhz_of = 6'd8;
         3'h4: mhz_of = 6'd12;
         3'h5: mhz_of = 6'd16;
         3'h6: mhz_of = 6'd32;
         default: mhz_of = 6'd0;
      endcase
   endfunction : mhz_of
   a_mode_pass: assert property (
      external_oscillator_mode == external_clock_mode_config) else $error("mode not passed");
   a_req_keeps_run: assert property (
      ({ext_osc_module_req, fast_osc_module_req, mid_osc_module_req, slow_osc_module_req,
        secondary_osc_module_req, rc_osc_module_req} & ~{external_oscillator_en,
        fast_internal_oscillator_en, mid_internal_oscillator_en, slow_internal_oscillator_en,
        secondary_osc_en, fast_rc_oscillator_en}) == 6'h00) else $error("request ignored");
   a_freq_decode: assert property (
      fast_osc_freq_mhz == mhz_of(fast_osc_freq_select)) else $error("bad decode");
   a_reset_freq: assert property ($rose(nrst) |=> fast_osc_freq_select ==
      (reset_clock_source_config == 3'h0 ? OETC_FRQ_32MHZ : OETC_FRQ_4MHZ))
      else $error("bad reset select");
   a_trim_reset: assert property (
      $rose(nrst) |-> fast_osc_trim == OETC_TRIM_RST) else $error("trim not zero");
   a_trim_cause: assert property ($changed(fast_osc_trim) |->
      $past(tune_event) || $past(reg_wr && reg_addr == OETC_ADDR_TRIM))
      else $error("trim moved alone");
   a_trim_step_one: assert property ($changed(fast_osc_trim) && !$past(reg_wr) |->
      6'(fast_osc_trim - $past(fast_osc_trim)) inside {6'h01, 6'h3f})
      else $error("trim step not one");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
   a_freq_read: assert property ($past(reg_rd && reg_addr == OETC_ADDR_FREQ) |->
      reg_rdata == {5'h00, $past(fast_osc_freq_select)}) else $error("freq readback");
   a_trim_read: assert property ($past(reg_rd && reg_addr == OETC_ADDR_TRIM) |->
      reg_rdata == {2'h0, $past(fast_osc_trim)}) else $error("trim readback");
endmodule : oetc_chk

bind oetc_osc_control oetc_chk u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reset_clock_source_config(reset_clock_source_config),
   .external_clock_mode_config(external_clock_mode_config),
   .ext_osc_module_req(ext_osc_module_req), .fast_osc_module_req(fast_osc_module_req),
   .mid_osc_module_req(mid_osc_module_req), .slow_osc_module_req(slow_osc_module_req),
   .secondary_osc_module_req(secondary_osc_module_req),
   .rc_osc_module_req(rc_osc_module_req), .tune_event(tune_event),
   .external_oscillator_en(external_oscillator_en),
   .fast_internal_oscillator_en(fast_internal_oscillator_en),
   .mid_internal_oscillator_en(mid_internal_oscillator_en),
   .slow_internal_oscillator_en(slow_internal_oscillator_en),
   .secondary_osc_en(secondary_osc_en), .fast_rc_oscillator_en(fast_rc_oscillator_en),
   .external_oscillator_mode(external_oscillator_mode),
   .fast_osc_freq_select(fast_osc_freq_select), .fast_osc_freq_mhz(fast_osc_freq_mhz),
   .fast_osc_trim(fast_osc_trim));

// ===== tb/tb.sv
`timescale 1ns/10ps
// ==========================================================
// register-level bench for the oscillator control block
module tb;
   import oetc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ev = 1'b0, band = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic [2:0] emode = 3'h5, mode, fsel;
   logic [2:0] rsto = 3'h0;
   logic [5:0] req = 6'h00, en, mhz, trim;
   logic hp, irq;
   oetc_cmp_t verdict = OETC_CMP_OK;
   int failures = 0, check_count = 0, cycles = 0;
   logic [5:0] mhz_tab [8] = '{6'd1, 6'd2, 6'd4, 6'd8, 6'd12, 6'd16, 6'd32, 6'd0};
   always #2 clk = ~clk;
   // en and req share the manual register's bit order, 7 down to 2
   oetc_osc_control u_dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
      .reset_clock_source_config(rsto), .external_clock_mode_config(emode),
      .ext_osc_module_req(req[5]), .fast_osc_module_req(req[4]), .mid_osc_module_req(req[3]),
      .slow_osc_module_req(req[2]), .secondary_osc_module_req(req[1]),
      .rc_osc_module_req(req[0]), .tune_event(ev), .tune_verdict(verdict),
      .tune_in_band(band), .external_oscillator_en(en[5]), .external_oscillator_mode(mode),
      .fast_internal_oscillator_en(en[4]), .fast_osc_freq_select(fsel),
      .fast_osc_freq_mhz(mhz), .fast_osc_trim(trim), .mid_internal_oscillator_en(en[3]),
      .slow_internal_oscillator_en(en[2]), .secondary_osc_en(en[1]),
      .secondary_osc_high_power(hp), .fast_rc_oscillator_en(en[0]), .irq(irq));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stands only in the cycle after the taking edge
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd
   task tick(input oetc_cmp_t v, input logic b);
      @(posedge clk);
      ev <= 1'b1;
      verdict <= v;
      band <= b;
      @(posedge clk);
      ev <= 1'b0;
   endtask : tick
   task results;
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // hang guard, far above the sequence length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         results();
      end
   end
   initial begin
      int i;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OETC_ADDR_FREQ, 8'h06);
      rd(OETC_ADDR_TRIM, 8'h00);
      rd(OETC_ADDR_ACT, 8'h00);
      chk({5'h00, mode}, {5'h00, emode});
      wr(OETC_ADDR_MANUAL, 8'hff);
      #1 chk({2'h0, en}, 8'h3f);
      rd(OETC_ADDR_MANUAL, 8'hfc);
      // each manual bit alone, then each module request alone
      for (i = 0; i < 6; i++) begin
         wr(OETC_ADDR_MANUAL, 8'h04 << i);
         #1 chk({2'h0, en}, 8'h01 << i);
      end
      wr(OETC_ADDR_MANUAL, 8'h00);
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         req <= 6'h01 << i;
         #1 chk({2'h0, en}, 8'h01 << i);
      end
      for (i = 0; i < 8; i++) begin
         wr(OETC_ADDR_FREQ, {5'h1f, i[2:0]});
         #1 chk({2'h0, mhz}, {2'h0, mhz_tab[i]});
         rd(OETC_ADDR_FREQ, {5'h00, i[2:0]});
      end
      wr(OETC_ADDR_PWR, 8'h01);
      #1 chk({7'h00, hp}, 8'h01);
      wr(OETC_ADDR_PWR, 8'h00);
      #1 chk({7'h00, hp}, 8'h00);
      wr(OETC_ADDR_TRIM, 8'hff);
      rd(OETC_ADDR_TRIM, 8'h3f);
      wr(OETC_ADDR_TRIM, 8'h1e);
      wr(OETC_ADDR_ACT, 8'h80);
      wr(OETC_ADDR_TRIM, 8'h05);
      rd(OETC_ADDR_TRIM, 8'h1e);
      tick(OETC_CMP_SLOW, 1'b0);
      tick(OETC_CMP_SLOW, 1'b0);
      rd(OETC_ADDR_TRIM, 8'h1f);
      rd(OETC_ADDR_ACT, 8'h82);
      rd(OETC_ADDR_IRQ_STAT, 8'h04);
      chk({7'h00, irq}, 8'h00);
      tick(OETC_CMP_FAST, 1'b1);
      rd(OETC_ADDR_TRIM, 8'h1e);
      rd(OETC_ADDR_ACT, 8'h88);
      wr(OETC_ADDR_IRQ_MASK, 8'h04);
      #1 chk({7'h00, irq}, 8'h01);
      wr(OETC_ADDR_IRQ_STAT, 8'h04);
      #1 chk({7'h00, irq}, 8'h00);
      rd(OETC_ADDR_IRQ_STAT, 8'h01);
      // pause freezes both the hardware and software paths
      wr(OETC_ADDR_ACT, 8'hc0);
      tick(OETC_CMP_SLOW, 1'b1);
      rd(OETC_ADDR_TRIM, 8'h1e);
      wr(OETC_ADDR_ACT, 8'h40);
      wr(OETC_ADDR_TRIM, 8'h07);
      rd(OETC_ADDR_TRIM, 8'h1e);
      wr(OETC_ADDR_ACT, 8'h00);
      wr(OETC_ADDR_TRIM, 8'h07);
      tick(OETC_CMP_SLOW, 1'b0);
      rd(OETC_ADDR_TRIM, 8'h07);
      chk({2'h0, trim}, 8'h07);
      wr(4'h8, 8'hff);
      rd(4'h8, 8'h00);
      // second reset with the 4 MHz strap, so the other reset select is seen
      @(posedge clk);
      rsto <= 3'h6;
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OETC_ADDR_FREQ, 8'h02);
      rd(OETC_ADDR_TRIM, 8'h00);
      rd(OETC_ADDR_ACT, 8'h00);
      results();
   end
endmodule : tb
